// *** rtl/ts_out_map.svh ***
// Register offsets, field positions, reset values and framing constants
// for the transport stream output stage. Included by the package users.
`ifndef TS_OUT_MAP_SVH
`define TS_OUT_MAP_SVH

`define ADDR_OUTCLK_RATIO 8'h21
`define ADDR_OUT_CTRL 8'h60
`define ADDR_CLK_CTRL 8'h61
`define ADDR_MONITOR_CTL 8'h67
`define ADDR_MON_HI 8'h7B
`define ADDR_MON_LO 8'h7C

`define RST_OUTCLK_RATIO 8'h00
`define RST_OUT_CTRL 8'h33
`define RST_CLK_CTRL 8'h00
`define RST_MONITOR_CTL 8'h00

`define OC_MANUAL 7
`define OC_ERR_INV 6
`define OC_CLK_POL 5
`define OC_TEI_EN 4
`define OC_SERIAL 3
`define OC_LOCK_HI 2
`define OC_LOCK_LO 0
`define CC_SR_DIS 7
`define MC_ERR_MODE 7
`define MC_SEL_HI 3
`define MC_SEL_LO 0

`define LEN_DVB 8'd188
`define LEN_ALT 8'd130
`define SYNC_BYTE 8'h47
`define RATIO_OFFSET 16'd6
`define LOCK_OFFSET 4'd2
`define R_DVB_NUM 40'd204
`define R_DVB_DEN 40'd193
`define R_ALT_NUM 40'd147
`define R_ALT_DEN 40'd135
`define Q_QPSK 40'd1
`define Q_BPSK 40'd2
`define P_PAR 40'd8
`define P_SER 40'd1
`define SYMPER_FRAC 4
`define TEI_BYTE 8'd1
`define TEI_BIT 7

`endif

// *** rtl/ts_out_pkg.sv ***
// Types shared by the transport stream output stage.
// Constants live in ts_out_map.svh.
package ts_out_pkg;
	typedef enum logic [1:0] {SRC_SYMBOL, SRC_DECIM, SRC_RATIO, SRC_EXT} clk_src_e;
	typedef enum logic {TX_IDLE, TX_SEND} tx_state_e;
	typedef logic [15:0] period_t;
endpackage

// *** rtl/ts_fifo.sv ***
// First-word-fall-through FIFO with registered head word and flags.
// Assumes DEPTH is a power of two; one clock, async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module ts_fifo #(
	parameter int W = 10,
	parameter int DEPTH = 16
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic [W-1:0] i_in_data,
	input wire logic i_in_valid,
	output logic o_in_ready,
	output logic [W-1:0] o_out_data,
	output logic o_out_valid,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic wr;
	logic rd;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] next_count;

	assign wr = i_in_valid & o_in_ready;
	assign rd = i_out_ready & o_out_valid;
	assign next_rd_ptr = rd ? rd_ptr + 1'b1 : rd_ptr;
	assign next_count = count + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};

	always_ff @(posedge i_clk_sys)
	begin
		if (wr)
			mem[wr_ptr] <= i_in_data;
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			o_in_ready <= 1'b0;
			o_out_valid <= 1'b0;
			o_out_data <= '0;
		end
		else
		begin
			if (wr)
				wr_ptr <= wr_ptr + 1'b1;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			o_in_ready <= next_count < DEPTH[AW:0];
			o_out_valid <= next_count != '0;
			// Bypass a word written into the slot that becomes the head
			if (wr && next_rd_ptr == wr_ptr)
				o_out_data <= i_in_data;
			else
				o_out_data <= mem[next_rd_ptr];
		end
	end
endmodule
`default_nettype wire

// *** rtl/transport_stream_output_ctrl.sv ***
// Transport stream output stage: byte clock generation, packet framing,
// error flag and monitor selection. Assumes the decoder delivers bytes
// with a packet-start mark and an uncorrectable mark on the first byte.
//
// Behaviour
// (RULE1) Byte period is truncated PLL-clock count formula
// (RULE2) Modulation factor one for QPSK, two BPSK
// (RULE3) Framing factor 204/193 or 147/135
// (RULE4) Factor eight parallel, one serial; Viterbi rate
// (RULE5) Stream clock is PLL rate over count
// (RULE6) Control bit 7 selects manual clock generation
// (RULE7) Bit 6 inverts the block error pin
// (RULE8) Bit 5 set gives normal clock polarity
// (RULE9) Polarity selects rising or falling launch edge
// (RULE10) Bit 4 forces error indicator on bad packets; code marks only DVB packets, not with i_alt_format set
// (RULE11) Bit 3 selects bit-serial output on line 0
// (RULE12) Aligner locks after field plus two syncs
// (RULE13) Hold mode: flag low until good packets
// (RULE14) Packet mode: flag low through last byte
// (RULE15) Monitor select picks monitor register pair
// (RULE16) Monitor codes map to listed internal values
// (RULE17) Two bits choose the output clock source
// (RULE18) Packets on consecutive clocks, gaps held low
// (RULE19) Start strobe for first byte clock only
// (RULE20) Valid strobe spans whole packet
// (RULE21) Reloading counter toggles clock each period
// (RULE22) Unused monitor codes read as zero
`timescale 1ns/1ns
`default_nettype none
`include "ts_out_map.svh"
module transport_stream_output_ctrl #(
	parameter int FIFO_DEPTH = 16,
	parameter int PER_W = 16
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	input wire logic [7:0] i_byte_data,
	input wire logic i_byte_first,
	input wire logic i_byte_uncorr,
	input wire logic i_byte_valid,
	output logic o_byte_ready,
	input wire logic i_bpsk_mode,
	input wire logic i_alt_format,
	input wire logic [2:0] i_code_rate_num,
	input wire logic [3:0] i_code_rate_den,
	input wire logic [15:0] i_symbol_period,
	input wire ts_out_pkg::period_t i_decim_period,
	input wire logic i_descrambler_lock,
	input wire logic i_external_byte_clock_in,
	input wire logic [15:0] i_mon_iq_samples,
	input wire logic [15:0] i_mon_dc_offsets,
	input wire logic [15:0] i_mon_symbol_rate,
	input wire logic [2:0] i_mon_decim_upper,
	input wire logic [7:0] i_mon_freq_lock,
	input wire logic [15:0] i_mon_timing_lock,
	input wire logic [15:0] i_mon_phase_lock,
	output logic o_output_byte_clock,
	output logic [7:0] o_packet_data_out,
	output logic o_packet_start_strobe,
	output logic o_packet_valid_strobe,
	output logic o_block_error_flag
);
	import ts_out_pkg::*;

	localparam int DIV_W = 40;
	localparam int FW = 10;

	logic [7:0] output_data_control;
	logic [7:0] clock_control;
	logic [7:0] monitor_control;
	logic [7:0] outclk_ratio;

	logic manual_outclk_select;
	logic symbol_rate_clock_disable;
	logic error_flag_invert;
	logic outclk_polarity;
	logic auto_error_mark_enable;
	logic bit_serial_select;
	logic [2:0] aligner_lock_count;
	logic error_flag_mode;
	logic [3:0] monitor_select;
	clk_src_e clk_src;

	assign manual_outclk_select = output_data_control[`OC_MANUAL];
	assign error_flag_invert = output_data_control[`OC_ERR_INV];
	assign outclk_polarity = output_data_control[`OC_CLK_POL];
	assign auto_error_mark_enable = output_data_control[`OC_TEI_EN];
	assign bit_serial_select = output_data_control[`OC_SERIAL];
	assign aligner_lock_count = output_data_control[`OC_LOCK_HI:`OC_LOCK_LO];
	assign symbol_rate_clock_disable = clock_control[`CC_SR_DIS];
	assign error_flag_mode = monitor_control[`MC_ERR_MODE];
	assign monitor_select = monitor_control[`MC_SEL_HI:`MC_SEL_LO];
	// RULE6 RULE17
	assign clk_src = clk_src_e'({manual_outclk_select, symbol_rate_clock_disable});

	// Monitor pair selection; the pair is captured when the high half is read
	function automatic logic [15:0] monitor_pair(input logic [3:0] sel);
		unique case (sel)
			4'h0: monitor_pair = i_mon_iq_samples;
			4'h1: monitor_pair = i_mon_dc_offsets;
			4'h3: monitor_pair = i_mon_symbol_rate;
			4'h5: monitor_pair = {i_mon_decim_upper, 13'h0000};
			4'h6: monitor_pair = {i_mon_freq_lock, i_mon_freq_lock};
			4'h7: monitor_pair = i_mon_timing_lock;
			4'h8: monitor_pair = i_mon_phase_lock;
			default: monitor_pair = 16'h0000; // RULE22
		endcase
	endfunction

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			output_data_control <= `RST_OUT_CTRL;
			clock_control <= `RST_CLK_CTRL;
			monitor_control <= `RST_MONITOR_CTL;
			outclk_ratio <= `RST_OUTCLK_RATIO;
		end
		else if (i_reg_wr)
		begin
			unique case (i_reg_addr)
				`ADDR_OUT_CTRL: output_data_control <= i_reg_wdata;
				`ADDR_CLK_CTRL: clock_control <= i_reg_wdata & 8'h80;
				`ADDR_MONITOR_CTL: monitor_control <= i_reg_wdata & 8'h8F;
				`ADDR_OUTCLK_RATIO: outclk_ratio <= i_reg_wdata;
				default: ;
			endcase
		end
	end

	logic [15:0] next_mon_pair;
	logic [15:0] mon_shadow;
	assign next_mon_pair = monitor_pair(monitor_select); // RULE15 RULE16

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_reg_rdata <= 8'h00;
			mon_shadow <= 16'h0000;
		end
		else if (i_reg_rd)
		begin
			unique case (i_reg_addr)
				`ADDR_OUT_CTRL: o_reg_rdata <= output_data_control;
				`ADDR_CLK_CTRL: o_reg_rdata <= clock_control;
				`ADDR_MONITOR_CTL: o_reg_rdata <= monitor_control;
				`ADDR_OUTCLK_RATIO: o_reg_rdata <= outclk_ratio;
				`ADDR_MON_HI:
				begin
					o_reg_rdata <= next_mon_pair[15:8];
					mon_shadow <= next_mon_pair;
				end
				`ADDR_MON_LO: o_reg_rdata <= mon_shadow[7:0];
				default: o_reg_rdata <= 8'h00;
			endcase
		end
	end

	// Serial restoring divider, rerun continuously so rate changes follow
	logic [DIV_W-1:0] div_res;
	logic [DIV_W-1:0] div_den;
	logic [DIV_W-1:0] div_rem;
	logic [DIV_W-1:0] div_quo;
	logic [DIV_W-1:0] div_rem_sh;
	logic [5:0] div_step;
	period_t period_sym;
	logic [DIV_W-1:0] q_fac;
	logic [DIV_W-1:0] p_fac;
	logic [DIV_W-1:0] r_num;
	logic [DIV_W-1:0] r_den;

	assign q_fac = i_bpsk_mode ? `Q_BPSK : `Q_QPSK; // RULE2
	assign r_num = i_alt_format ? `R_ALT_NUM : `R_DVB_NUM; // RULE3
	assign r_den = i_alt_format ? `R_ALT_DEN : `R_DVB_DEN; // RULE3
	assign p_fac = bit_serial_select ? `P_SER : `P_PAR; // RULE4
	assign div_rem_sh = {div_rem[DIV_W-2:0], div_quo[DIV_W-1]};
	// Last quotient bit folded in here so the period follows within one run
	assign div_res = {div_quo[DIV_W-2:0], div_rem_sh >= div_den} >> `SYMPER_FRAC;

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			div_den <= '0;
			div_rem <= '0;
			div_quo <= '0;
			div_step <= '0;
			period_sym <= 16'h0002;
		end
		else if (div_step == '0)
		begin
			// RULE1 RULE4: N = Q*R*P*(1/V)*(PLL/RS)/2, symbol period carries fraction bits
			div_quo <= q_fac * r_num * p_fac * DIV_W'(i_code_rate_den) * DIV_W'(i_symbol_period);
			div_den <= (r_den * DIV_W'(i_code_rate_num)) << 1;
			div_rem <= '0;
			div_step <= 6'(DIV_W);
		end
		else
		begin
			if (div_rem_sh >= div_den && div_den != '0)
			begin
				div_rem <= div_rem_sh - div_den;
				div_quo <= {div_quo[DIV_W-2:0], 1'b1};
			end
			else
			begin
				div_rem <= div_rem_sh;
				div_quo <= {div_quo[DIV_W-2:0], 1'b0};
			end
			div_step <= div_step - 1'b1;
			if (div_step == 6'd1)
			begin
				// RULE1: truncation drops the fraction bits
				if (div_res[DIV_W-1:PER_W] != '0)
					period_sym <= '1;
				else if (div_res[PER_W-1:0] < 16'h0002)
					period_sym <= 16'h0002;
				else
					period_sym <= div_res[PER_W-1:0];
			end
		end
	end

	// Byte clock generator
	period_t period;
	period_t gen_cnt;
	period_t next_gen_cnt;
	logic gen_high;
	logic next_gen_high;
	logic ext_q;
	logic launch;

	always_comb
	begin
		unique case (clk_src) // RULE17
			SRC_SYMBOL: period = period_sym;
			SRC_DECIM: period = (i_decim_period < 16'h0002) ? 16'h0002 : i_decim_period;
			SRC_RATIO: period = {8'h00, outclk_ratio} + `RATIO_OFFSET;
			SRC_EXT: period = 16'h0002;
		endcase
		// RULE21 RULE5: reload after period clocks, high for the first half
		next_gen_cnt = (gen_cnt >= period - 1'b1) ? '0 : gen_cnt + 1'b1;
		next_gen_high = (clk_src == SRC_EXT) ? i_external_byte_clock_in : next_gen_cnt < (period >> 1);
		gen_high = (clk_src == SRC_EXT) ? ext_q : gen_cnt < (period >> 1);
		// Data launches when the internal clock falls; the pin polarity flip
		// turns that into a rising or falling pin edge
		launch = gen_high & ~next_gen_high; // RULE9
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			gen_cnt <= '0;
			ext_q <= 1'b0;
			o_output_byte_clock <= 1'b0;
		end
		else
		begin
			gen_cnt <= next_gen_cnt;
			ext_q <= i_external_byte_clock_in;
			o_output_byte_clock <= outclk_polarity ? next_gen_high : ~next_gen_high; // RULE8
		end
	end

	// Input buffer: decoder bytes with first and uncorrectable marks
	logic [FW-1:0] head;
	logic head_valid;
	logic pop;

	ts_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_in_data({i_byte_uncorr, i_byte_first, i_byte_data}),
		.i_in_valid(i_byte_valid),
		.o_in_ready(o_byte_ready),
		.o_out_data(head),
		.o_out_valid(head_valid),
		.i_out_ready(pop)
	);

	// Framer
	tx_state_e state;
	logic [7:0] cur_byte;
	logic [7:0] byte_idx;
	logic [2:0] bit_idx;
	logic [3:0] sync_cnt;
	logic aligned;
	logic pkt_bad;
	logic err_low;
	logic next_err_low;
	logic [7:0] pkt_len;
	logic head_first;
	logic start_pkt;
	logic next_byte;
	logic pkt_end;
	logic [7:0] out_byte;

	assign pkt_len = i_alt_format ? `LEN_ALT : `LEN_DVB;
	assign head_first = head[8];

	always_comb
	begin
		start_pkt = launch && state == TX_IDLE && head_valid && head_first && aligned;
		next_byte = launch && state == TX_SEND && (!bit_serial_select || bit_idx == 3'd7);
		pkt_end = next_byte && byte_idx == pkt_len - 1'b1;
		// Bytes outside an aligned packet are drained and dropped
		pop = start_pkt || (next_byte && !pkt_end && head_valid) ||
			(launch && state == TX_IDLE && head_valid && !(head_first && aligned));
		out_byte = head[7:0];
		// RULE10
		if (auto_error_mark_enable && !i_alt_format && pkt_bad && byte_idx + 1'b1 == `TEI_BYTE)
			out_byte[`TEI_BIT] = 1'b1;
	end

	// RULE12: count consecutive good sync words at each packet head
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			sync_cnt <= '0;
			aligned <= 1'b0;
		end
		else if (pop && head_first)
		begin
			if (i_alt_format || head[7:0] == `SYNC_BYTE)
			begin
				if (sync_cnt < {1'b0, aligner_lock_count} + `LOCK_OFFSET)
					sync_cnt <= sync_cnt + 1'b1;
				aligned <= aligned || sync_cnt + 1'b1 >= {1'b0, aligner_lock_count} + `LOCK_OFFSET;
			end
			else
			begin
				sync_cnt <= '0;
				aligned <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state <= TX_IDLE;
			cur_byte <= 8'h00;
			byte_idx <= 8'h00;
			bit_idx <= 3'd0;
			pkt_bad <= 1'b0;
			o_packet_data_out <= 8'h00;
			o_packet_start_strobe <= 1'b0;
			o_packet_valid_strobe <= 1'b0;
		end
		else if (launch)
		begin
			o_packet_start_strobe <= start_pkt; // RULE19
			if (start_pkt)
			begin
				state <= TX_SEND;
				cur_byte <= head[7:0];
				pkt_bad <= head[9];
				byte_idx <= 8'h00;
				bit_idx <= 3'd0;
				o_packet_valid_strobe <= 1'b1; // RULE20
				// RULE11
				o_packet_data_out <= bit_serial_select ? {7'h00, head[7]} : head[7:0];
			end
			else if (state == TX_IDLE || pkt_end)
			begin
				// RULE18: lines held low between packets
				state <= TX_IDLE;
				o_packet_valid_strobe <= 1'b0; // RULE20
				o_packet_data_out <= 8'h00;
			end
			else if (!next_byte)
			begin
				bit_idx <= bit_idx + 1'b1;
				o_packet_data_out <= {7'h00, cur_byte[3'd6 - bit_idx]}; // RULE11
			end
			else if (head_valid)
			begin
				// RULE18: an empty buffer mid-packet stretches the current byte
				cur_byte <= out_byte;
				byte_idx <= byte_idx + 1'b1;
				bit_idx <= 3'd0;
				o_packet_data_out <= bit_serial_select ? {7'h00, out_byte[7]} : out_byte;
			end
		end
	end

	always_comb
	begin
		next_err_low = err_low;
		if (error_flag_mode)
		begin
			// RULE13
			if (!i_descrambler_lock)
				next_err_low = 1'b1;
			else if (start_pkt)
				next_err_low = head[9];
		end
		else
		begin
			// RULE14
			if (start_pkt)
				next_err_low = head[9];
			else if (pkt_end)
				next_err_low = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			err_low <= 1'b0;
			o_block_error_flag <= 1'b1;
		end
		else
		begin
			err_low <= next_err_low;
			o_block_error_flag <= error_flag_invert ? next_err_low : ~next_err_low; // RULE7
		end
	end
endmodule
`default_nettype wire

// *** testbench/ts_sink_model.sv ***
// Receiving end of the stream port: a demultiplexer that samples the pins.
// Assumes launch on the falling pin edge, so it samples on the rising one.
`timescale 1ns/1ns
`default_nettype none
module ts_sink_model (
	input wire logic i_clk,
	input wire logic [7:0] i_data,
	input wire logic i_start,
	input wire logic i_valid,
	input wire logic i_flag
);
	logic [7:0] b1, tag;
	logic f0;
	logic inpkt = 0;
	int n = 0;
	int errs = 0;
	logic [7:0] m_b1 [8];
	logic m_f0 [8];
	logic m_fend [8];
	int m_len [8];
	// Start must land on the launch edge, never on the sampling edge
	always @(posedge i_start)
	begin
		#1;
		if (i_clk !== 1'b0)
			errs++;
	end
	always @(posedge i_clk)
	begin
		if (i_valid)
		begin
			n = i_start ? 0 : n + 1;
			if (i_start)
				f0 = i_flag;
			if (n == 1)
				b1 = i_data;
			if (n == 2)
				tag = i_data;
			if (i_start == inpkt)
				errs++;
			inpkt = 1;
		end
		else
		begin
			if (i_data !== 8'h00)
				errs++;
			if (inpkt)
			begin
				m_b1[tag[2:0]] = b1;
				m_f0[tag[2:0]] = f0;
				m_fend[tag[2:0]] = i_flag;
				m_len[tag[2:0]] = n + 1;
			end
			inpkt = 0;
		end
	end
endmodule
`default_nettype wire

// *** testbench/transport_stream_output_ctrl_chk.sv ***
// Port-level assertions for the stream output stage.
// Sees only top-level ports; bound from the testbench top file.
`timescale 1ns/1ns
`default_nettype none
`include "ts_out_map.svh"
module ts_out_chk (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	input wire logic o_output_byte_clock,
	input wire logic [7:0] o_packet_data_out,
	input wire logic o_packet_start_strobe,
	input wire logic o_packet_valid_strobe
);
	logic mapped;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_nrst);
	assign mapped = i_reg_addr inside {`ADDR_OUTCLK_RATIO, `ADDR_OUT_CTRL, `ADDR_CLK_CTRL,
		`ADDR_MONITOR_CTL, `ADDR_MON_HI, `ADDR_MON_LO};
	start_in_valid_a: assert property (o_packet_start_strobe |-> o_packet_valid_strobe)
		else $error("start strobe outside packet");
	valid_with_start_a: assert property ($rose(o_packet_valid_strobe) |-> o_packet_start_strobe)
		else $error("packet began without start");
	start_single_a: assert property ($fell(o_packet_start_strobe) |-> o_packet_valid_strobe)
		else $error("start strobe spanned packet");
	gap_low_a: assert property (!o_packet_valid_strobe |-> o_packet_data_out == 8'h00)
		else $error("data not low in gap");
	data_on_edge_a: assert property ($changed(o_packet_data_out) |-> $changed(o_output_byte_clock))
		else $error("data moved off clock edge");
	valid_on_edge_a: assert property ($changed(o_packet_valid_strobe) |-> $changed(o_output_byte_clock))
		else $error("valid moved off clock edge");
	unmapped_zero_a: assert property (i_reg_rd && !mapped |=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
		else $error("read data moved without read");
endmodule
`default_nettype wire

// *** testbench/tb_transport_stream_output_ctrl.sv ***
// Self-checking bench for the stream output stage.
// Drives registers and bytes, measures the byte clock, judges packets via the sink.
`timescale 1ns/1ns
`default_nettype none
`include "ts_out_map.svh"
module tb_transport_stream_output_ctrl;
	import ts_out_pkg::*;
	logic clk = 0, nrst = 0, wr = 0, rd = 0, bf = 0, bu = 0, bv = 0, bpsk = 0, alt = 0;
	logic dlock = 1, ext = 0, brdy, pin, pst, pval, pflag;
	logic [7:0] addr = 8'h00, wdata = 8'h00, bd = 8'h00, rdata, pdata;
	logic [2:0] crn = 3'd1;
	logic [3:0] crd = 4'd2;
	logic [15:0] symp = 16'h0010;
	period_t decp = 16'h000A;
	logic [15:0] miq = 16'h1234, mdc = 16'h5678, msr = 16'h9ABC, mtl = 16'h0F1E, mpl = 16'h2D3C;
	logic [7:0] mfl = 8'hDE;
	int ecnt = 0;
	int err_count = 0;
	int n_checks = 0;
	transport_stream_output_ctrl transport_stream_output_ctrl_inst (
		.i_clk_sys(clk), .i_nrst(nrst), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_byte_data(bd),
		.i_byte_first(bf), .i_byte_uncorr(bu), .i_byte_valid(bv), .o_byte_ready(brdy),
		.i_bpsk_mode(bpsk), .i_alt_format(alt), .i_code_rate_num(crn), .i_code_rate_den(crd),
		.i_symbol_period(symp), .i_decim_period(decp), .i_descrambler_lock(dlock),
		.i_external_byte_clock_in(ext), .i_mon_iq_samples(miq), .i_mon_dc_offsets(mdc),
		.i_mon_symbol_rate(msr), .i_mon_decim_upper(3'h5), .i_mon_freq_lock(mfl),
		.i_mon_timing_lock(mtl), .i_mon_phase_lock(mpl), .o_output_byte_clock(pin),
		.o_packet_data_out(pdata), .o_packet_start_strobe(pst), .o_packet_valid_strobe(pval),
		.o_block_error_flag(pflag));
	ts_sink_model ts_sink_model_inst (.i_clk(pin), .i_data(pdata), .i_start(pst),
		.i_valid(pval), .i_flag(pflag));
	always #20 clk = !clk;
	// External byte clock: twelve system clocks a period
	always @(posedge clk)
	begin
		ecnt <= (ecnt == 5) ? 0 : ecnt + 1;
		if (ecnt == 5)
			ext <= !ext;
	end
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	task wreg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
		@(posedge clk);
	endtask
	task rreg(input logic [7:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		@(posedge clk);
		d = rdata;
	endtask
	task per(input int e, input string nm);
		time t;
		// Long enough for the rate divider to finish a run on new settings
		repeat (16) @(posedge pin);
		t = $time;
		@(posedge pin);
		chk(nm, 16'(e), 16'(($time - t) / 40));
	endtask
	task hi(input int e, input string nm);
		time t;
		@(posedge pin);
		@(posedge pin);
		t = $time;
		@(negedge pin);
		chk(nm, 16'(e), 16'(($time - t) / 40));
	endtask
	task send(input logic [7:0] k, input logic bad);
		int i;
		logic r;
		i = 0;
		while (i < 188)
		begin
			bd <= (i == 0) ? `SYNC_BYTE : (i == 2) ? k : 8'(i);
			bf <= (i == 0);
			bu <= bad && (i == 0);
			bv <= 1;
			@(negedge clk);
			r = brdy;
			@(posedge clk);
			if (r)
				i++;
		end
	endtask
	task wpkt(input int k);
		int w;
		w = 0;
		bv <= 0;
		while (ts_sink_model_inst.m_len[k] == 0 && w < 5000)
		begin
			@(posedge clk);
			w++;
		end
		if (w == 5000)
		begin
			$display("CHECK FAILED packet %0d done expected 1 seen 0", k);
			err_count++;
		end
	endtask
	task t_regs;
		logic [7:0] d;
		rreg(`ADDR_OUT_CTRL, d);
		chk("out ctrl reset", 8'h33, d);
		rreg(`ADDR_MONITOR_CTL, d);
		chk("monitor reset", 8'h00, d);
		rreg(8'h10, d);
		chk("unmapped read", 8'h00, d);
		wreg(`ADDR_MONITOR_CTL, 8'h7F);
		rreg(`ADDR_MONITOR_CTL, d);
		chk("monitor reserved", 8'h0F, d);
		$display("register test done");
	endtask
	task t_mon;
		logic [15:0] e;
		logic [7:0] h, l;
		for (int c = 0; c < 16; c++)
		begin
			case (c)
				0: e = miq;
				1: e = mdc;
				3: e = msr;
				5: e = {3'h5, 13'h0000};
				6: e = {mfl, mfl};
				7: e = mtl;
				8: e = mpl;
				default: e = 16'h0000;
			endcase
			wreg(`ADDR_MONITOR_CTL, 8'(c));
			rreg(`ADDR_MON_HI, h);
			rreg(`ADDR_MON_LO, l);
			chk("monitor pair", e, {h, l});
		end
		$display("monitor test done");
	endtask
	task t_clk;
		per(8, "symbol qpsk");
		@(posedge clk);
		bpsk <= 1;
		per(16, "symbol bpsk");
		@(posedge clk);
		symp <= 16'h0040;
		alt <= 1;
		per(69, "symbol alt");
		wreg(`ADDR_OUT_CTRL, 8'h3B);
		per(8, "symbol serial");
		crn <= 3'd3;
		crd <= 4'd4;
		per(5, "symbol rate");
		wreg(`ADDR_CLK_CTRL, 8'h80);
		per(10, "decimation");
		wreg(`ADDR_OUTCLK_RATIO, 8'h05);
		wreg(`ADDR_OUT_CTRL, 8'hB3);
		per(12, "external");
		wreg(`ADDR_CLK_CTRL, 8'h00);
		per(11, "ratio");
		hi(5, "clock high normal");
		wreg(`ADDR_OUT_CTRL, 8'h93);
		hi(6, "clock high inverted");
		alt <= 0;
		$display("clock test done");
	endtask
	task t_pkt;
		wreg(`ADDR_OUTCLK_RATIO, 8'h00);
		wreg(`ADDR_OUT_CTRL, 8'hB0);
		for (int k = 0; k < 5; k++)
			send(8'(k), k == 3);
		wpkt(4);
		chk("marked byte", 8'h81, ts_sink_model_inst.m_b1[3]);
		chk("clean byte", 8'h01, ts_sink_model_inst.m_b1[4]);
		chk("length", 16'd188, 16'(ts_sink_model_inst.m_len[3]));
		chk("flag bad start", 0, ts_sink_model_inst.m_f0[3]);
		chk("flag after bad", 1, ts_sink_model_inst.m_fend[3]);
		chk("flag good start", 1, ts_sink_model_inst.m_f0[4]);
		chk("sink faults", 0, 16'(ts_sink_model_inst.errs));
		$display("packet test done");
	endtask
	task t_flag;
		wreg(`ADDR_OUT_CTRL, 8'hF0);
		repeat (8) @(posedge clk);
		chk("flag inverted", 0, pflag);
		wreg(`ADDR_OUT_CTRL, 8'hB0);
		wreg(`ADDR_MONITOR_CTL, 8'h80);
		dlock <= 0;
		repeat (8) @(posedge clk);
		chk("flag lock loss", 0, pflag);
		dlock <= 1;
		repeat (8) @(posedge clk);
		chk("flag held low", 0, pflag);
		send(8'd5, 1'b0);
		wpkt(5);
		chk("flag good resume", 1, ts_sink_model_inst.m_f0[5]);
		$display("flag test done");
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#1_000_000;
		err_count++;
		$display("watchdog expired");
		stop_test;
	end
	initial
	begin
		repeat (6) @(posedge clk);
		nrst <= 1;
		repeat (2) @(posedge clk);
		t_regs;
		t_mon;
		t_clk;
		t_pkt;
		t_flag;
		stop_test;
	end
endmodule
bind transport_stream_output_ctrl ts_out_chk ts_out_chk_inst (.i_clk_sys(i_clk_sys),
	.i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
	.o_output_byte_clock(o_output_byte_clock), .o_packet_data_out(o_packet_data_out),
	.o_packet_start_strobe(o_packet_start_strobe),
	.o_packet_valid_strobe(o_packet_valid_strobe));
`default_nettype wire
